// File: core/sar_pkg.sv
// ====================================================================
// Constants and types of the conversion sequencer
package sar_pkg;
   // Core clock
   localparam int CLK_NS = 8;
   // Internal oscillator period, 13 pulses fit well under 25 us
   localparam int INT_CLK_NS = 1600;
   localparam logic [7:0] INT_HALF_CYC =
      8'(INT_CLK_NS / (2 * CLK_NS));
   // Longest internal-clock conversion times
   localparam int MAX12_NS  = 25000;
   localparam int MAX10_NS  = 22000;
   localparam int MAX8_NS   = 18000;
   localparam int MAX12_CYC = MAX12_NS / CLK_NS;
   localparam int MAX10_CYC = MAX10_NS / CLK_NS;
   localparam int MAX8_CYC  = MAX8_NS / CLK_NS;
   // Fastest external clock
   localparam int EXT_MIN_NS = 1250;
   // Result width and pulse counter value on the last (13th) pulse
   localparam int NBITS = 12;
   localparam logic [3:0] LAST_PULSE = 4'hc;
   localparam logic [11:0] SAR_RST = 12'hfff;
   // Wishbone byte offsets
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_STAT = 4'h4;
   localparam logic [3:0] ADR_RES  = 4'h8;
   // Control fields and reset value
   localparam int CTRL_AUTO_BIT = 0;
   localparam int CTRL_CONV_BIT = 1;
   localparam logic CTRL_AUTO_RST = 1'h0;
   // Result buffer depth
   localparam logic [1:0] FIFO_DEPTH = 2'h2;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_CONV = 1'b1
   } sar_state_t;

   typedef struct packed {
      logic        short_cyc;
      logic [11:0] code;
   } sar_res_t;
endpackage

// File: core/sar_seq.sv
`timescale 1ns/1ns
// ====================================================================
// Contract
// - Internal clock: start on convert rise; oscillator runs only while busy.
// - Clock and inhibit pins pulled up; both open selects internal clock.
// - External clock up to 800 kHz gives a 15 us 12-bit conversion.
// - Continuous mode, free external clock: 14th pulse starts next one.
// - Short-cycle input ends conversion after bits decided so far.
// - Short-cycle tied to next bit output ends right after the wanted bit.
// - Internal clock conversion at most 25, 22 or 18 us by length.
// - Outputs complementary: a true bit reads as logic 0.
// - Near full scale codes toggle FFE/FFF and 000/001, complement coded.
// - Bit n decided on pulse n+1; status falls after the 13th rising edge.
// - Convert commands during a conversion are ignored.
// - Serial result only during conversion, MSB first, with clock output.
module sar_seq (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [3:0]       wb_adr_i,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   input  wire logic             convert_i,
   input  wire logic             ext_clk_i,
   input  wire logic             ext_clk_drv_i,
   input  wire logic             clk_inh_i,
   input  wire logic             clk_inh_drv_i,
   input  wire logic             short_cycle_n_i,
   input  wire logic             comp_i,
   output logic      [11:0]      bits_o,
   output logic                  msb_n_o,
   output logic                  status_o,
   output logic                  serial_o,
   output logic                  conv_clk_o,
   output logic                  res_valid_o,
   input  wire logic             res_ready_i,
   output sar_pkg::sar_res_t     res_data_o
);

   // =================================================================
   // Pin synchronisers
   logic [4:0]  pin_raw;
   logic [4:0]  sync1_q;
   logic [4:0]  sync2_q;
   logic [1:0]  prev_q;
   logic        conv_s;
   logic        ext_s;
   logic        inh_s;
   logic        sc_n_s;
   logic        comp_s;

   // Undriven clock pins read high, as a pull-up would leave them
   assign pin_raw = {convert_i,
                     ext_clk_drv_i ? ext_clk_i : 1'b1,
                     clk_inh_drv_i ? clk_inh_i : 1'b1,
                     short_cycle_n_i,
                     comp_i};

   // Two stages; the 8 ns sampling resolves an 800 kHz clock easily
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= 5'h1e;
         sync2_q <= 5'h1e;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
      end
   end

   assign {conv_s, ext_s, inh_s, sc_n_s, comp_s} = sync2_q;

   // Previous samples of convert and external clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_q <= 2'h3;
      end else begin
         prev_q <= {conv_s, ext_s};
      end
   end

   // =================================================================
   // Clock source and internal oscillator
   logic        ext_mode;
   logic        ext_rise;
   logic [7:0]  div_q;
   logic        int_clk_q;
   logic        int_rise;
   logic        conv_rise;
   sar_pkg::sar_state_t state_q;
   logic        busy_q;

   assign busy_q   = (state_q == sar_pkg::ST_CONV);
   assign ext_mode = !inh_s;
   assign ext_rise = ext_s && !prev_q[0];
   assign int_rise = busy_q && !ext_mode && !int_clk_q
                     && (div_q == sar_pkg::INT_HALF_CYC - 8'h01);
   assign conv_rise = ext_mode ? (busy_q && ext_rise) : int_rise;

   // Oscillator held stopped and low whenever idle
   always_ff @(posedge clk_i) begin
      if (rst_i || !busy_q || ext_mode) begin
         div_q     <= 8'h00;
         int_clk_q <= 1'b0;
      end else if (div_q == sar_pkg::INT_HALF_CYC - 8'h01) begin
         div_q     <= 8'h00;
         int_clk_q <= !int_clk_q;
      end else begin
         div_q     <= div_q + 8'h01;
      end
   end

   // =================================================================
   // Result buffer, two entries
   sar_pkg::sar_res_t mem_q [0:1];
   logic        wr_ptr_q;
   logic        rd_ptr_q;
   logic [1:0]  fcnt_q;
   logic        fifo_full;
   logic        push_q;
   logic        pop;

   assign fifo_full   = (fcnt_q == sar_pkg::FIFO_DEPTH);
   assign res_valid_o = (fcnt_q != 2'h0);
   assign res_data_o  = mem_q[rd_ptr_q];
   assign pop         = res_valid_o && res_ready_i;

   // =================================================================
   // Start control
   logic        auto_q;
   logic        sw_conv_q;
   logic        cmd_rise;
   logic        auto_start;
   logic        start;
   logic        sc_end;
   logic [3:0]  cnt_q;

   // A full buffer stalls new starts; a start in the push cycle sees the stale count and can overwrite the oldest result
   assign cmd_rise   = (conv_s && !prev_q[1]) || sw_conv_q;
   assign auto_start = auto_q && ext_mode && ext_rise;
   assign start      = !busy_q && !fifo_full
                       && (cmd_rise || auto_start);
   assign sc_end     = busy_q && !conv_rise && !sc_n_s
                       && (cnt_q != 4'h0);

   // =================================================================
   // Approximation register and sequencing
   logic [11:0] sar_q;
   logic        ser_q;
   logic        short_q;

   // Bit n is tested on pulse n and decided on pulse n+1
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= sar_pkg::ST_IDLE;
         cnt_q   <= 4'h0;
         sar_q   <= sar_pkg::SAR_RST;
         ser_q   <= 1'b0;
         short_q <= 1'b0;
      end else if (start) begin
         state_q <= sar_pkg::ST_CONV;
         cnt_q   <= 4'h0;
         sar_q   <= sar_pkg::SAR_RST;
         ser_q   <= 1'b0;
         short_q <= 1'b0;
      end else if (conv_rise) begin
         cnt_q <= cnt_q + 4'h1;
         if (cnt_q != 4'h0) begin
            // True decision keeps the trial 0
            sar_q[4'hc - cnt_q] <= !comp_s;
            ser_q <= !comp_s && (cnt_q != sar_pkg::LAST_PULSE);
         end
         if (cnt_q < sar_pkg::LAST_PULSE) begin
            sar_q[4'hb - cnt_q] <= 1'b0;
         end
         if (cnt_q == sar_pkg::LAST_PULSE) begin
            state_q <= sar_pkg::ST_IDLE;
         end
      end else if (sc_end) begin
         // Undecided trial bit returns to false, status drops now
         state_q             <= sar_pkg::ST_IDLE;
         sar_q[4'hc - cnt_q] <= 1'b1;
         ser_q               <= 1'b0;
         short_q             <= 1'b1;
      end
   end

   // Completion pulse feeds the buffer one cycle later
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         push_q <= 1'b0;
      end else begin
         push_q <= busy_q && (sc_end ||
                   (conv_rise && cnt_q == sar_pkg::LAST_PULSE));
      end
   end

   // Buffer storage and pointers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         fcnt_q   <= 2'h0;
         mem_q[0] <= '0;
         mem_q[1] <= '0;
      end else begin
         if (push_q) begin
            mem_q[wr_ptr_q] <= '{short_cyc: short_q, code: sar_q};
            wr_ptr_q        <= !wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= !rd_ptr_q;
         end
         fcnt_q <= fcnt_q + {1'b0, push_q} - {1'b0, pop};
      end
   end
   // Clock copy rises with each pulse edge, so pulse 13 is shown too
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         conv_clk_o <= 1'b0;
      end else begin
         conv_clk_o <= busy_q && (conv_rise || (conv_clk_o
                       && (ext_mode ? ext_s : int_clk_q)));
      end
   end

   assign bits_o   = sar_q;
   assign msb_n_o  = !sar_q[sar_pkg::NBITS - 1];
   assign status_o = busy_q;
   assign serial_o = ser_q;

   // =================================================================
   // Wishbone slave, one wait state, writes land on the ack edge
   logic        ack_q;
   logic [31:0] rdat_q;
   logic        wr_en;

   assign wr_en    = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // Ack handshake
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      end
   end

   // Control register; software start is a single-cycle pulse
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         auto_q    <= sar_pkg::CTRL_AUTO_RST;
         sw_conv_q <= 1'b0;
      end else if (wr_en && wb_sel_i[0]
                   && wb_adr_i == sar_pkg::ADR_CTRL) begin
         auto_q    <= wb_dat_i[sar_pkg::CTRL_AUTO_BIT];
         sw_conv_q <= wb_dat_i[sar_pkg::CTRL_CONV_BIT];
      end else begin
         sw_conv_q <= 1'b0;
      end
   end

   // Read mux; unmapped offsets read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_q <= 32'h0000_0000;
      end else if (!(wb_cyc_i && wb_stb_i)) begin
         rdat_q <= 32'h0000_0000;
      end else if (wb_adr_i == sar_pkg::ADR_CTRL) begin
         rdat_q <= {31'h0000_0000, auto_q};
      end else if (wb_adr_i == sar_pkg::ADR_STAT) begin
         rdat_q <= {27'h000_0000, fcnt_q, short_q, ext_mode, busy_q};
      end else if (wb_adr_i == sar_pkg::ADR_RES) begin
         rdat_q <= {20'h0_0000, sar_q};
      end else begin
         rdat_q <= 32'h0000_0000;
      end
   end

   // =================================================================
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   int unsigned tm_q;

   // Conversion length counter for the internal clock
   always_ff @(posedge clk_i) begin
      if (rst_i || !busy_q || ext_mode) begin
         tm_q <= 0;
      end else begin
         tm_q <= tm_q + 1;
      end
   end

   sequence s_last_pulse;
      busy_q && conv_rise && cnt_q == sar_pkg::LAST_PULSE;
   endsequence

   sequence s_first_true;
      busy_q && conv_rise && cnt_q == 4'h1 && comp_s;
   endsequence

   property p_start;
      !busy_q && !fifo_full && cmd_rise |=> busy_q && cnt_q == 4'h0;
   endproperty
   a_start: assert property (p_start) else $error("no start");

   property p_osc_idle;
      !busy_q ##1 !busy_q |-> !int_clk_q && div_q == 8'h00;
   endproperty
   a_osc_idle: assert property (p_osc_idle) else $error("osc runs");

   property p_pullup;
      (!clk_inh_drv_i)[*3] |-> !ext_mode;
   endproperty
   a_pullup: assert property (p_pullup) else $error("pull-up");

   property p_src;
      busy_q && ext_mode && conv_rise |-> ext_rise && !int_clk_q;
   endproperty
   a_src: assert property (p_src) else $error("bad source");

   property p_end13;
      s_last_pulse |=> !busy_q && push_q;
   endproperty
   a_end13: assert property (p_end13) else $error("no end");

   property p_decide;
      s_first_true |=> !sar_q[11] && !sar_q[10];
   endproperty
   a_decide: assert property (p_decide) else $error("bit 1");

   property p_ignore;
      busy_q && cmd_rise && !conv_rise && !sc_end |=> busy_q
         && cnt_q == $past(cnt_q);
   endproperty
   a_ignore: assert property (p_ignore) else $error("restart");

   property p_short;
      sc_end |=> !busy_q && short_q && push_q;
   endproperty
   a_short: assert property (p_short) else $error("short");

   property p_auto;
      !busy_q && !fifo_full && auto_start |=> busy_q;
   endproperty
   a_auto: assert property (p_auto) else $error("auto");

   property p_serial;
      !busy_q ##1 !busy_q |-> !serial_o && !conv_clk_o;
   endproperty
   a_serial: assert property (p_serial) else $error("serial");

   property p_time;
      busy_q && !ext_mode |-> tm_q < sar_pkg::MAX12_CYC;
   endproperty
   a_time: assert property (p_time) else $error("too slow");

endmodule

// File: test/sar_front_model.sv
`timescale 1ns/1ns
// ====================================================================
// Analog front end: comparator and short-cycle strap
module sar_front_model (
   input  wire logic [11:0] bits_i,
   input  wire logic [11:0] vin_i,
   input  wire logic [3:0]  res_i,
   output logic             comp_o,
   output logic             short_n_o
);
   logic [11:0] dac;

   // Trial level is the true-sense code on the complementary bit pins
   assign dac = ~bits_i;
   // Input at or above the trial keeps the bit; ties count as above
   assign comp_o = (vin_i >= dac);
   // Strap to the pin after the wanted length; open pin reads high
   assign short_n_o = (res_i == 4'hc) ? 1'b1 : bits_i[4'hb - res_i];
endmodule

// File: test/tb_top.sv
`timescale 1ns/1ns
// ====================================================================
// Bench for the conversion sequencer
module tb_top;
   logic              clk_i = 1'b0;
   logic              rst_i = 1'b1;
   logic [3:0]        wb_adr_i = 4'h0;
   logic [3:0]        wb_sel_i = 4'h0;
   logic              wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [31:0]       wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
   logic              wb_ack_o, comp, short_n, status_o, serial_o;
   logic              convert_i = 1'b0, ext_clk_i = 1'b1, clk_inh_i = 1'b1;
   logic              ext_clk_drv_i = 1'b0, clk_inh_drv_i = 1'b0;
   logic              conv_clk_o, msb_n_o, res_valid_o, res_ready_i = 1'b0;
   logic [11:0]       bits_o, vin = 12'h000, last_code;
   logic [3:0]        res_len = 4'hc;
   sar_pkg::sar_res_t res_data_o;
   logic [31:0]       rnd = 32'h97f7_928e, rs = 32'h97f7_928e;
   logic              stall = 1'b0, ext_run = 1'b0, pst = 1'b0, pcc = 1'b0;
   logic [12:0]       exp_q[$];
   logic [11:0]       edge_v [0:3] = '{12'h000, 12'h001, 12'hffe, 12'hfff};
   int                errors = 0, check_count = 0;

   sar_seq i_sar_seq (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .convert_i(convert_i), .ext_clk_i(ext_clk_i),
      .ext_clk_drv_i(ext_clk_drv_i), .clk_inh_i(clk_inh_i),
      .clk_inh_drv_i(clk_inh_drv_i), .short_cycle_n_i(short_n),
      .comp_i(comp), .bits_o(bits_o), .msb_n_o(msb_n_o),
      .status_o(status_o), .serial_o(serial_o), .conv_clk_o(conv_clk_o),
      .res_valid_o(res_valid_o), .res_ready_i(res_ready_i),
      .res_data_o(res_data_o));
   sar_front_model i_sar_front_model (.bits_i(bits_o), .vin_i(vin),
      .res_i(res_len), .comp_o(comp), .short_n_o(short_n));

   // ====================================================================
   // Clocks: core 8 ns, link 125 ns only within frames, idles high
   always #4 clk_i = ~clk_i;
   always begin
      if (ext_run) begin
         #63 ext_clk_i = 1'b0;
         #62 ext_clk_i = 1'b1;
      end else
         #5;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      if (errors == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Bounded wait; a hang counts as a mismatch
   task automatic wait_st(input logic v, input int lim);
      int n;
      n = 0;
      while (status_o !== v && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= lim) begin
         errors++;
         wrap_up();
      end
   endtask

   // Classic single cycle, held until ack is sampled
   task automatic wb(input logic [3:0] a, input logic we,
                     input logic [31:0] d);
      int n;
      n = 0;
      wb_adr_i <= a;
      wb_we_i <= we;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 20) begin
         errors++;
         wrap_up();
      end
      @(posedge clk_i);
   endtask

   task automatic drain();
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 300) begin
         @(posedge clk_i);
         n++;
      end
      check(32'(exp_q.size()), 32'h0);
   endtask

   // One conversion; mode 0 pin, 1 pin synced to link clock, 2 register
   task automatic conv(input logic [3:0] len, input logic [1:0] mode,
                       input logic [11:0] v);
      int n, np, lim;
      logic pc;
      logic [11:0] ser, mask;
      n = 0;
      np = 0;
      pc = 1'b0;
      ser = 12'h000;
      mask = 12'hfff >> len;
      last_code = ~v | mask;
      lim = (len == 4'hc) ? sar_pkg::MAX12_CYC :
            (len == 4'ha) ? sar_pkg::MAX10_CYC : sar_pkg::MAX8_CYC;
      vin <= v;
      res_len <= len;
      exp_q.push_back({len != 4'hc, last_code});
      ext_run = (mode == 2'h1);
      if (mode == 2'h1)
         @(negedge ext_clk_i);
      @(posedge clk_i);
      if (mode == 2'h2)
         wb(sar_pkg::ADR_CTRL, 1'b1, 32'h0000_0002);
      else
         convert_i <= 1'b1;
      wait_st(1'b1, 10);
      convert_i <= 1'b0;
      // Second command mid-run must not restart or queue
      while (status_o === 1'b1 && n < 4000) begin
         @(posedge clk_i);
         n++;
         if (n == 300)
            convert_i <= 1'b1;
         if (n == 303)
            convert_i <= 1'b0;
         if (conv_clk_o === 1'b1 && pc === 1'b0) begin
            np++;
            if (np >= 2 && np <= len)
               ser = {ser[10:0], serial_o};
         end
         pc = conv_clk_o;
      end
      ext_run = 1'b0;
      check({31'h0, status_o}, 32'h0);
      check(32'(np), 32'(len) + 32'h1);
      check({20'h0, ser}, {20'h0, (~v & ~mask) >> (4'hd - len)});
      check({19'h0, msb_n_o, bits_o},
            {19'h0, ~last_code[11], last_code});
      if (mode != 2'h1)
         check({31'h0, n <= lim}, 32'h1);
      // Gap well beyond the minimum after the last pulse
      repeat (20) @(posedge clk_i);
   endtask

   // ====================================================================
   // Random consumer stalls; checker pops the oldest note per word
   always @(posedge clk_i) begin
      rs <= lfsr(rs);
      res_ready_i <= ~stall & rs[7];
      if (!rst_i && res_valid_o === 1'b1 && res_ready_i === 1'b1) begin
         if (exp_q.size() == 0)
            check({19'h0, res_data_o}, 32'hffff_ffff);
         else
            check({19'h0, res_data_o}, {19'h0, exp_q.pop_front()});
      end
      if (clk_inh_drv_i === 1'b0 && conv_clk_o === 1'b1 && pcc === 1'b0)
         check({31'h0, status_o | pst}, 32'h1);
      pst <= status_o;
      pcc <= conv_clk_o;
   end

   // ====================================================================
   // Main sequence
   initial begin
      int n, k;
      logic p, e;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      check({16'h0, status_o, serial_o, conv_clk_o, res_valid_o, bits_o},
            32'h0000_0fff);
      wb(sar_pkg::ADR_CTRL, 1'b0, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      wb(4'hc, 1'b0, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      wb(sar_pkg::ADR_STAT, 1'b0, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         conv(4'hc - 4'(2 * i), 2'h0, rnd[11:0]);
      end
      wb(sar_pkg::ADR_RES, 1'b0, 32'h0000_0000);
      check(rd, {20'h0, last_code});
      wb(sar_pkg::ADR_STAT, 1'b0, 32'h0000_0000);
      check(rd & 32'h0000_0007, 32'h0000_0004);
      rnd = lfsr(rnd);
      conv(4'hc, 2'h2, rnd[11:0]);
      // Two-entry buffer: fill, refuse a start, then drain
      drain();
      stall <= 1'b1;
      repeat (2) begin
         rnd = lfsr(rnd);
         conv(4'hc, 2'h0, rnd[11:0]);
      end
      wb(sar_pkg::ADR_STAT, 1'b0, 32'h0000_0000);
      check(rd, 32'h0000_0010);
      convert_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      check({31'h0, status_o}, 32'h0);
      convert_i <= 1'b0;
      stall <= 1'b0;
      drain();
      // External clock: inhibit grounded, clock driven
      clk_inh_drv_i <= 1'b1;
      clk_inh_i <= 1'b0;
      ext_clk_drv_i <= 1'b1;
      for (int i = 0; i < 4; i++)
         conv(4'hc, 2'h1, edge_v[i]);
      rnd = lfsr(rnd);
      conv(4'ha, 2'h1, rnd[11:0]);
      // Continuous mode on a free link clock: 14 link clock rises from one start to the next
      wb(sar_pkg::ADR_CTRL, 1'b1, 32'h0000_0001);
      vin <= rnd[23:12];
      res_len <= 4'hc;
      exp_q.push_back({1'b0, ~rnd[23:12]});
      exp_q.push_back({1'b0, ~rnd[23:12]});
      ext_run = 1'b1;
      wait_st(1'b1, 100);
      n = 0;
      k = 0;
      do begin
         p = status_o;
         e = ext_clk_i;
         @(posedge clk_i);
         n++;
         if (ext_clk_i === 1'b1 && e === 1'b0)
            k++;
      end while (!(status_o === 1'b1 && p === 1'b0) && n < 600);
      check(32'(k), 32'd14);
      wait_st(1'b0, 400);
      wb(sar_pkg::ADR_CTRL, 1'b1, 32'h0000_0000);
      ext_run = 1'b0;
      drain();
      wrap_up();
   end
endmodule
